// File: parallel_host_port.sv
// Purpose: eight-bit parallel host port with separate read and write strobes
// Assumes: host pins are asynchronous to clock; one clock domain
// Notes:   audio bytes buffered in two registered-output fifos
//
// Operation
// - eight-bit data, two-bit select, four registers
// - separate inbound and outbound message bytes
// - bit six holds coded input in reset
// - bit five holds linear input in reset
// - bit four shows linear fifo near full
// - bit three shows coded fifo near full
// - inbound pending: host write sets, core clears
// - outbound valid: core write sets, host clears
// - select two feeds linear audio fifo
// - select three feeds coded audio fifo
// - attention low while outbound byte waits, enabled
// - attention also for unsolicited outgoing messages
// - byte captured when write strobe ends
// - device drives selected register during read
// - port unusable with external memory attached
`timescale 1ns/1ps
`include "parallel_host_port_defines.svh"

////////////////////////////////////////////////////////////////////////////////

module audio_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int LW    = `FIFO_LEVEL_W
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data,
  // occupancy
  output      logic [LW-1:0]    level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [LW-1:0]    mem_count;
  logic             push;
  logic             pop;

  assign in_ready = (mem_count < LW'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (mem_count != '0) && (!out_valid || out_ready);
  assign level    = mem_count + LW'(out_valid);

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      mem_count <= '0;
    end else if (flush) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      mem_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      mem_count <= mem_count + LW'(push) - LW'(pop);
    end
  end

  // output stage register so the drain side sees flip-flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (flush) begin
      out_valid <= 1'b0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule // audio_fifo

////////////////////////////////////////////////////////////////////////////////

module parallel_host_port (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // host pins
  input  wire logic       chip_select_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [1:0] register_select,
  input  wire logic [7:0] data_in,
  output      logic [7:0] data_out,
  output      logic       data_oe,
  output      logic       attention_n,
  // strap and option levels
  input  wire logic       ext_memory_present,
  input  wire logic       attention_enable,
  // core side of the message port
  output      logic [7:0] inbound_data,
  output      logic       inbound_pending,
  input  wire logic       core_inbound_read,
  input  wire logic [7:0] core_outbound_data,
  input  wire logic       core_outbound_write,
  output      logic       outbound_valid,
  // channel resets seen by the core
  output      logic       coded_input_reset,
  output      logic       linear_input_reset,
  // linear audio stream
  output      logic       linear_valid,
  input  wire logic       linear_ready,
  output      logic [7:0] linear_data,
  // coded audio stream
  output      logic       coded_valid,
  input  wire logic       coded_ready,
  output      logic [7:0] coded_data
);

  logic                               rst_meta_b;
  logic                               rst_sync_b;
  logic [12:0]                        pin_s1;
  logic [12:0]                        pin_s2;
  logic [12:0]                        pin_s3;
  logic [12:0]                        pin_filt;
  logic [12:0]                        pin_agree;
  logic                               cs_act;
  logic                               wr_act;
  logic                               rd_act;
  logic [1:0]                         sel_f;
  logic [7:0]                         data_f;
  logic                               port_enable;
  parallel_host_port_pkg::host_cycle_t cycle;
  parallel_host_port_pkg::host_cycle_t next_cycle;
  logic [1:0]                         held_sel;
  logic [7:0]                         held_data;
  logic                               write_done;
  logic                               read_done;
  logic [7:0]                         outbound_byte;
  logic                               linear_near_full;
  logic                               coded_near_full;
  logic [7:0]                         status_byte;
  logic [7:0]                         next_data_out;
  logic                               lin_push;
  logic                               cod_push;
  logic                               lin_in_ready;
  logic                               cod_in_ready;
  logic [`FIFO_LEVEL_W-1:0]           lin_level;
  logic [`FIFO_LEVEL_W-1:0]           cod_level;

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a bit changes once stages two and three agree

  assign pin_agree = ~(pin_s2 ^ pin_s3);

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_s1   <= `RST_PINS;
      pin_s2   <= `RST_PINS;
      pin_s3   <= `RST_PINS;
      pin_filt <= `RST_PINS;
    end else begin
      pin_s1   <= {chip_select_n, write_strobe_n, read_strobe_n, register_select, data_in};
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_filt <= (pin_s2 & pin_agree) | (pin_filt & ~pin_agree);
    end
  end

  assign cs_act = ~pin_filt[12];
  assign wr_act = ~pin_filt[11];
  assign rd_act = ~pin_filt[10];
  assign sel_f  = pin_filt[9:8];
  assign data_f = pin_filt[7:0];

  // shared data lines belong to the memory interface when it is fitted
  assign port_enable = ~ext_memory_present;

  //////////////////////////////////////////////////////////////////////////////
  // host cycle tracking

  always_comb begin
    next_cycle = cycle;
    write_done = 1'b0;
    read_done  = 1'b0;
    case (cycle)
      parallel_host_port_pkg::CYCLE_IDLE: begin
        if (port_enable && cs_act && wr_act) begin
          next_cycle = parallel_host_port_pkg::CYCLE_WRITE;
        end else if (port_enable && cs_act && rd_act) begin
          next_cycle = parallel_host_port_pkg::CYCLE_READ;
        end
      end
      parallel_host_port_pkg::CYCLE_WRITE: begin
        if (!(cs_act && wr_act)) begin
          next_cycle = parallel_host_port_pkg::CYCLE_IDLE;
          write_done = 1'b1;
        end
      end
      parallel_host_port_pkg::CYCLE_READ: begin
        if (!(cs_act && rd_act)) begin
          next_cycle = parallel_host_port_pkg::CYCLE_IDLE;
          read_done  = 1'b1;
        end
      end
      default: begin
        next_cycle = parallel_host_port_pkg::CYCLE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cycle <= parallel_host_port_pkg::CYCLE_IDLE;
    end else begin
      cycle <= next_cycle;
    end
  end

  // select and data are tracked while the strobe is low, used at its end
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      held_sel  <= `SEL_MESSAGE_PORT;
      held_data <= `RST_BYTE;
    end else if (next_cycle != parallel_host_port_pkg::CYCLE_IDLE) begin
      held_sel  <= sel_f;
      held_data <= data_f;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // message port: two independent bytes

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      inbound_data <= `RST_BYTE;
    end else if (write_done && held_sel == `SEL_MESSAGE_PORT) begin
      inbound_data <= held_data;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      outbound_byte <= `RST_BYTE;
    end else if (core_outbound_write) begin
      outbound_byte <= core_outbound_data;
    end
  end

  // set wins over clear on both handshake flags
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      inbound_pending <= 1'b0;
    end else if (write_done && held_sel == `SEL_MESSAGE_PORT) begin
      inbound_pending <= 1'b1;
    end else if (core_inbound_read) begin
      inbound_pending <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      outbound_valid <= 1'b0;
    end else if (core_outbound_write) begin
      outbound_valid <= 1'b1;
    end else if (read_done && held_sel == `SEL_MESSAGE_PORT) begin
      outbound_valid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control bits; reserved bits 7 and 0 are not stored

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      coded_input_reset  <= 1'b0;
      linear_input_reset <= 1'b0;
    end else if (write_done && held_sel == `SEL_CONTROL_STATUS) begin
      coded_input_reset  <= held_data[`BIT_CODED_INPUT_RESET];
      linear_input_reset <= held_data[`BIT_LINEAR_INPUT_RESET];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // near-full flags

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      linear_near_full <= 1'b0;
      coded_near_full  <= 1'b0;
    end else begin
      linear_near_full <= (lin_level >= `FIFO_THRESHOLD);
      coded_near_full  <= (cod_level >= `FIFO_THRESHOLD);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data path; write-only bits and audio selects read as zero

  always_comb begin
    status_byte                          = `RST_BYTE;
    status_byte[`BIT_LINEAR_NEAR_FULL]   = linear_near_full;
    status_byte[`BIT_CODED_NEAR_FULL]    = coded_near_full;
    status_byte[`BIT_INBOUND_PENDING]    = inbound_pending;
    status_byte[`BIT_OUTBOUND_VALID]     = outbound_valid;
    case (sel_f)
      `SEL_MESSAGE_PORT:   next_data_out = outbound_byte;
      `SEL_CONTROL_STATUS: next_data_out = status_byte;
      default:             next_data_out = `RST_BYTE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_out <= `RST_BYTE;
      data_oe  <= 1'b0;
    end else if (port_enable && next_cycle == parallel_host_port_pkg::CYCLE_READ) begin
      data_out <= next_data_out;
      data_oe  <= 1'b1;
    end else begin
      data_oe  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // attention line, solicited or not

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      attention_n <= 1'b1;
    end else begin
      attention_n <= ~(attention_enable && outbound_valid);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // audio input fifos; a byte arriving while full is dropped

  assign lin_push = write_done && held_sel == `SEL_LINEAR_AUDIO_PORT && !linear_input_reset
                    && lin_in_ready;
  assign cod_push = write_done && held_sel == `SEL_CODED_AUDIO_PORT && !coded_input_reset
                    && cod_in_ready;

  audio_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .LW    (`FIFO_LEVEL_W)
  ) linear_fifo (
    .clock     (clock),
    .rst_b     (rst_sync_b),
    .flush     (linear_input_reset),
    .in_valid  (lin_push),
    .in_ready  (lin_in_ready),
    .in_data   (held_data),
    .out_valid (linear_valid),
    .out_ready (linear_ready),
    .out_data  (linear_data),
    .level     (lin_level)
  );

  audio_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .LW    (`FIFO_LEVEL_W)
  ) coded_fifo (
    .clock     (clock),
    .rst_b     (rst_sync_b),
    .flush     (coded_input_reset),
    .in_valid  (cod_push),
    .in_ready  (cod_in_ready),
    .in_data   (held_data),
    .out_valid (coded_valid),
    .out_ready (coded_ready),
    .out_data  (coded_data),
    .level     (cod_level)
  );

endmodule // parallel_host_port

// File: parallel_host_port_defines.svh
// Purpose: constants for the eight-bit parallel host port
// Assumes: included by its bare name
// Notes:   offsets are the two-bit register select values
`ifndef PARALLEL_HOST_PORT_DEFINES_SVH
`define PARALLEL_HOST_PORT_DEFINES_SVH

// register selects
`define SEL_MESSAGE_PORT        2'h0
`define SEL_CONTROL_STATUS      2'h1
`define SEL_LINEAR_AUDIO_PORT   2'h2
`define SEL_CODED_AUDIO_PORT    2'h3

// control / status bit positions
`define BIT_CODED_INPUT_RESET   6
`define BIT_LINEAR_INPUT_RESET  5
`define BIT_LINEAR_NEAR_FULL    4
`define BIT_CODED_NEAR_FULL     3
`define BIT_INBOUND_PENDING     2
`define BIT_OUTBOUND_VALID      1

// reset values
`define RST_BYTE                8'h00
`define RST_PINS                13'h1FFF

// audio fifos
`define FIFO_WIDTH              8
`define FIFO_DEPTH              32
`define FIFO_LEVEL_W            6
`define FIFO_THRESHOLD          6'h18

`endif

// File: parallel_host_port_pkg.sv
// Purpose: types for the eight-bit parallel host port
// Assumes: nothing
// Notes:   one-hot host cycle states
package parallel_host_port_pkg;

  typedef enum logic [2:0] {
    CYCLE_IDLE  = 3'b001,
    CYCLE_WRITE = 3'b010,
    CYCLE_READ  = 3'b100
  } host_cycle_t;

endpackage

// File: parallel_host_port_asserts.sv
// Purpose: port assertions for the parallel host port
// Assumes: bound to parallel_host_port, host pins settle a few clocks
// Notes:   windows of eight clocks cover the pin filter latency
`timescale 1ns/1ps
module parallel_host_port_asserts (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // host pins
  input wire logic       chip_select_n,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [1:0] register_select,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       attention_n,
  // levels
  input wire logic       ext_memory_present,
  input wire logic       attention_enable,
  // core side
  input wire logic       inbound_pending,
  input wire logic       core_inbound_read,
  input wire logic       core_outbound_write,
  input wire logic       outbound_valid,
  input wire logic       linear_input_reset,
  input wire logic       linear_valid,
  input wire logic       linear_ready,
  input wire logic [7:0] linear_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence read_held;
    (!chip_select_n && !read_strobe_n && write_strobe_n && !ext_memory_present) [*8];
  endsequence
  sequence idle_held;
    chip_select_n [*8];
  endsequence

  AST_READ_DRIVE:
    assert property (read_held |-> data_oe) else $error("data lines idle during read");
  AST_IDLE_RELEASE:
    assert property (idle_held |-> !data_oe) else $error("data lines held after read");
  AST_EXT_MEMORY:
    assert property (ext_memory_present [*8] |-> !data_oe) else $error("port drove with memory");
  AST_AUDIO_READ_ZERO:
    assert property ((register_select[1] [*8]) ##0 data_oe |-> data_out == 8'h00)
      else $error("audio port read not zero");
  AST_CONTROL_READ_BITS:
    assert property ((register_select == 2'h1) [*8] ##0 data_oe |-> (data_out & 8'hE1) == 8'h00)
      else $error("write-only or reserved status bits not zero");
  AST_OUTBOUND_SET:
    assert property (core_outbound_write |=> outbound_valid) else $error("outbound flag not set");
  AST_INBOUND_CLEAR:
    assert property (idle_held ##0 core_inbound_read |=> !inbound_pending)
      else $error("inbound flag not cleared");
  AST_ATTENTION:
    assert property (attention_n == !($past(outbound_valid) && $past(attention_enable)))
      else $error("attention line wrong");
  AST_LINEAR_HOLD:
    assert property (linear_valid && !linear_ready && !linear_input_reset
      |=> linear_valid && $stable(linear_data)) else $error("linear stream dropped byte");
endmodule // parallel_host_port_asserts

bind parallel_host_port parallel_host_port_asserts parallel_host_port_asserts_i (
  .clock, .rst_b, .chip_select_n, .write_strobe_n, .read_strobe_n, .register_select,
  .data_out, .data_oe, .attention_n, .ext_memory_present, .attention_enable,
  .inbound_pending, .core_inbound_read, .core_outbound_write, .outbound_valid,
  .linear_input_reset, .linear_valid, .linear_ready, .linear_data
);

// File: host_model.sv
// Purpose: behavioural host processor on the parallel port pins
// Assumes: pins change one ns after a rising clock edge
// Notes:   strobes held eight clocks on reads, nine on writes, to pass the pin filter
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       clock,
  // host pins
  output      logic       chip_select_n,
  output      logic       write_strobe_n,
  output      logic       read_strobe_n,
  output      logic [1:0] register_select,
  output      logic [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  initial begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    register_select = 2'h0;
    data_in = 8'hFF;
  end

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic write_byte(input logic [1:0] sel, input logic [7:0] value);
    register_select = sel;
    wait_edges(1);
    chip_select_n = 1'b0;
    write_strobe_n = 1'b0;
    wait_edges(1);
    data_in = value;
    wait_edges(8);
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    wait_edges(8);
    // released bus shows no stale byte
    data_in = ~value;
  endtask

  task automatic write_control(input logic [7:0] value);
    write_byte(2'h1, value & 8'h7E);
  endtask

  task automatic read_byte(input logic [1:0] sel, output logic [7:0] value, output logic driven);
    register_select = sel;
    wait_edges(1);
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    wait_edges(8);
    value = data_out;
    driven = data_oe;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    wait_edges(8);
  endtask
endmodule // host_model

// File: parallel_host_port_bench.sv
// Purpose: self-checking bench for the parallel host port
// Assumes: host_model drives the pins, bench drives the core side
// Notes:   inputs change one ns after the rising edge
`timescale 1ns/1ps
module parallel_host_port_bench;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic       chip_select_n, write_strobe_n, read_strobe_n, data_oe, attention_n;
  logic [1:0] register_select;
  logic [7:0] data_in, data_out, inbound_data, linear_data, coded_data;
  logic       ext_memory_present = 1'b0;
  logic       attention_enable = 1'b1;
  logic       core_inbound_read = 1'b0;
  logic       core_outbound_write = 1'b0;
  logic [7:0] core_outbound_data = 8'h00;
  logic       ready = 1'b0;
  logic       inbound_pending, outbound_valid, coded_input_reset, linear_input_reset;
  logic       linear_valid, coded_valid;
  logic [7:0] v;
  logic       d;
  int         fail_count = 0;
  int         checks = 0;

  always #2.5 clock = ~clock;

  host_model host_model_i (.clock(clock), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .register_select(register_select), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));

  parallel_host_port parallel_host_port_i (.clock(clock), .rst_b(rst_b),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .register_select(register_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .attention_n(attention_n),
    .ext_memory_present(ext_memory_present), .attention_enable(attention_enable),
    .inbound_data(inbound_data), .inbound_pending(inbound_pending),
    .core_inbound_read(core_inbound_read), .core_outbound_data(core_outbound_data),
    .core_outbound_write(core_outbound_write), .outbound_valid(outbound_valid),
    .coded_input_reset(coded_input_reset), .linear_input_reset(linear_input_reset),
    .linear_valid(linear_valid), .linear_ready(ready), .linear_data(linear_data),
    .coded_valid(coded_valid), .coded_ready(ready), .coded_data(coded_data));

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    checks++;
    if (seen !== expected) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic send_msg(input logic [7:0] value);
    for (int k = 0; k < 20; k++) begin
      host_model_i.read_byte(2'h1, v, d);
      if (v[2] === 1'b0) begin
        host_model_i.write_byte(2'h0, value);
        return;
      end
    end
    fail_count++;
    summarize();
  endtask

  task automatic core_send(input logic [7:0] value);
    core_outbound_data = value;
    core_outbound_write = 1'b1;
    step(1);
    core_outbound_write = 1'b0;
    step(2);
  endtask

  task automatic t_reset();
    check({inbound_pending, outbound_valid, attention_n, data_oe}, 8'h02);
    host_model_i.read_byte(2'h1, v, d);
    check(v & 8'h1E, 8'h00);
  endtask

  task automatic t_message();
    send_msg(8'hA5);
    step(4);
    check(inbound_data, 8'hA5);
    host_model_i.read_byte(2'h1, v, d);
    check(v[2], 1'b1);
    core_send(8'h3C);
    check(attention_n, 1'b0);
    core_inbound_read = 1'b1;
    step(1);
    core_inbound_read = 1'b0;
    step(1);
    check(inbound_pending, 1'b0);
    host_model_i.read_byte(2'h0, v, d);
    check(v, 8'h3C);
    check(d, 1'b1);
    check(inbound_data, 8'hA5);
    check({outbound_valid, attention_n}, 8'h01);
    attention_enable = 1'b0;
    core_send(8'h5A);
    check(attention_n, 1'b1);
    host_model_i.read_byte(2'h1, v, d);
    check(v[1], 1'b1);
    send_msg(8'hC3);
    host_model_i.read_byte(2'h0, v, d);
    check(v, 8'h5A);
    check(inbound_data, 8'hC3);
    core_inbound_read = 1'b1;
    step(1);
    core_inbound_read = 1'b0;
    attention_enable = 1'b1;
  endtask

  task automatic t_control();
    host_model_i.write_control(8'hFF);
    check({coded_input_reset, linear_input_reset}, 8'h03);
    host_model_i.write_byte(2'h2, 8'h77);
    ready = 1'b1;
    step(4);
    check(linear_valid, 1'b0);
    ready = 1'b0;
    host_model_i.read_byte(2'h1, v, d);
    check(v & 8'h61, 8'h00);
    host_model_i.write_control(8'h00);
    check({coded_input_reset, linear_input_reset}, 8'h00);
  endtask

  task automatic t_fifo(input logic coded);
    int n;
    n = 0;
    for (int i = 0; i < 40; i++) host_model_i.write_byte({1'b1, coded}, 8'(i));
    host_model_i.read_byte(2'h1, v, d);
    check(coded ? v[3] : v[4], 1'b1);
    ready = 1'b1;
    for (int k = 0; k < 120; k++) begin
      if (coded ? coded_valid : linear_valid) begin
        check(coded ? coded_data : linear_data, 8'(n));
        n++;
      end
      step(1);
    end
    ready = 1'b0;
    check(n >= 32 && n <= 33, 1'b1);
    host_model_i.read_byte(2'h1, v, d);
    check(v & 8'h18, 8'h00);
  endtask

  task automatic t_refuse();
    host_model_i.read_byte(2'h2, v, d);
    check(v, 8'h00);
    ext_memory_present = 1'b1;
    step(2);
    host_model_i.write_byte(2'h0, 8'h11);
    check(inbound_pending, 1'b0);
    host_model_i.read_byte(2'h1, v, d);
    check(d, 1'b0);
    ext_memory_present = 1'b0;
  endtask

  initial begin
    step(12);
    rst_b = 1'b1;
    step(6);
    t_reset();
    t_message();
    t_control();
    t_fifo(1'b0);
    t_fifo(1'b1);
    t_refuse();
    summarize();
  end
endmodule // parallel_host_port_bench
